// ==== rtl/sre_top.sv ====
// security area erase sequencer: link decoder, status and erase timer
// assumes serial pins already synchronous to CLK, sampled at 125 MHz
//
// Overview of operation
// - three independent 256-byte security areas
// - erase accepted only with write enable latched
// - address bits 15..12 pick areas one..three
// - chip select must rise right after bit 32
// - valid frame starts self-timed area erase
// - busy high throughout erase, low when done
// - status reads keep working during erase
// - write enable latch clears after erase
// - locked areas ignore erase frames
// - erase accepted in single-line mode only
`timescale 1ns/1ps
`default_nettype none
`include "sre_consts.svh"

module sre_top #(
	parameter int ERASE_CYCLES = `SRE_ERASE_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// serial link
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SI,
	output logic SO,
	output logic SO_OE_N,
	// mode and protection
	input wire logic QPI_MODE,
	input wire logic [2:0] OTP_AREA_LOCK_BITS,
	// status
	output logic BUSY,
	output logic WRITE_ENABLE_LATCH,
	// area read port
	input wire logic [1:0] AREA_RD_SEL,
	input wire logic [7:0] AREA_RD_ADDR,
	output logic [7:0] AREA_RD_DATA,
	// area program port
	input wire logic AREA_WR_EN,
	input wire logic [1:0] AREA_WR_SEL,
	input wire logic [7:0] AREA_WR_ADDR,
	input wire logic [7:0] AREA_WR_DATA
);

	localparam logic [23:0] ERASE_LAST = 24'(ERASE_CYCLES - 1);

	sre_if link_if ();

	// pin history for edge detection
	logic sclk_q;
	logic cs_n_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;

	// link receiver state
	sre_pkg::sre_link_t link_st;
	sre_pkg::sre_link_t next_link_st;
	logic [31:0] command_address_bits;
	logic [31:0] next_command_address_bits;
	logic [5:0] bit_cnt;
	logic [5:0] next_bit_cnt;
	logic [2:0] out_idx;
	logic [2:0] next_out_idx;
	logic so;
	logic next_so;
	logic so_oe_n;
	logic next_so_oe_n;

	// erase engine and latches
	sre_pkg::sre_erase_t erase_st;
	sre_pkg::sre_erase_t next_erase_st;
	logic [23:0] erase_cnt;
	logic [23:0] next_erase_cnt;
	logic wipe_seen;
	logic next_wipe_seen;
	logic busy;
	logic next_busy;
	logic we_latch;
	logic next_we_latch;
	logic start;
	logic next_start;
	sre_pkg::sre_area_t area;
	sre_pkg::sre_area_t next_area;
	logic [7:0] rd_data;

	// decoded frame terms
	logic [7:0] opcode_short;
	logic [7:0] opcode_long;
	logic [7:0] shifted_opcode;
	logic erase_ok;
	logic [7:0] stat_now;

	// area number from an erase address, 0 when the layout does not match
	function automatic sre_pkg::sre_area_t area_of(input logic [31:0] frame);
		logic [3:0] sel;
		sel = frame[`SRE_ADDR_SEL_MSB:`SRE_ADDR_SEL_LSB];
		area_of = 2'h0;
		if (frame[`SRE_ADDR_HI_MSB:`SRE_ADDR_HI_LSB] == 8'h00 &&
			frame[`SRE_ADDR_MID_MSB:`SRE_ADDR_MID_LSB] == 4'h0 &&
			sel >= 4'h1 && sel <= 4'h3) begin
			area_of = sel[1:0];
		end
	endfunction

	// lock bit for an area; area 0 counts as locked so it never erases
	function automatic logic is_locked(input sre_pkg::sre_area_t a, input logic [2:0] locks);
		is_locked = 1'b1;
		if (a != 2'h0) begin
			is_locked = locks[a - 2'h1];
		end
	endfunction

	// status byte as shifted out by the read-status command
	function automatic logic [7:0] status_byte(input logic b, input logic w);
		status_byte = 8'h00;
		status_byte[`SRE_STAT_BUSY] = b;
		status_byte[`SRE_STAT_WE_LATCH] = w;
	endfunction

	// edges of the sampled pins
	assign sclk_rise = SCLK & ~sclk_q;
	assign sclk_fall = ~SCLK & sclk_q;
	assign cs_fall = ~CS_N & cs_n_q;
	assign cs_rise = CS_N & ~cs_n_q;

	assign opcode_short = command_address_bits[7:0];
	assign opcode_long = command_address_bits[31:24];
	assign shifted_opcode = {command_address_bits[6:0], SI};
	// live status byte; a function result cannot be bit-selected directly
	assign stat_now = status_byte(busy, we_latch);

	// every condition of an accepted erase frame at chip select rise
	assign erase_ok = (link_st == sre_pkg::SRE_L_SHIFT) && cs_rise &&
		(bit_cnt == `SRE_BITS_ERASE) &&
		(opcode_long == `SRE_OP_ERASE) &&
		we_latch &&
		!busy &&
		!QPI_MODE &&
		!is_locked(area_of(command_address_bits), OTP_AREA_LOCK_BITS);

	// link receiver: shift on rising clock, drive status on falling
	always_comb begin
		next_link_st = link_st;
		next_command_address_bits = command_address_bits;
		next_bit_cnt = bit_cnt;
		next_out_idx = out_idx;
		next_so = so;
		next_so_oe_n = so_oe_n;
		if (CS_N) begin
			// frame ends on any chip select rise, whatever its length
			next_link_st = sre_pkg::SRE_L_IDLE;
			next_so_oe_n = 1'b1;
		end else if (cs_fall || link_st == sre_pkg::SRE_L_IDLE) begin
			next_link_st = sre_pkg::SRE_L_SHIFT;
			next_command_address_bits = 32'h0000_0000;
			next_bit_cnt = 6'h00;
			next_out_idx = 3'h0;
		end else begin
			case (link_st)
				sre_pkg::SRE_L_SHIFT: begin
					if (sclk_rise) begin
						next_command_address_bits = {command_address_bits[30:0], SI};
						// saturate so an overlong frame never wraps to 32
						if (bit_cnt != 6'h3f) begin
							next_bit_cnt = bit_cnt + 6'h01;
						end
						if (bit_cnt == `SRE_BITS_OPCODE - 6'h01 &&
							shifted_opcode == `SRE_OP_RDSR && !QPI_MODE) begin
							next_link_st = sre_pkg::SRE_L_STAT;
						end
					end
				end
				sre_pkg::SRE_L_STAT: begin
					// status is sampled live so busy drops mid-poll
					if (sclk_fall) begin
						next_so = stat_now[3'h7 - out_idx];
						next_so_oe_n = 1'b0;
						next_out_idx = out_idx + 3'h1;
					end
				end
				default: begin
					next_link_st = sre_pkg::SRE_L_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			link_st <= sre_pkg::SRE_L_IDLE;
			command_address_bits <= 32'h0000_0000;
			bit_cnt <= 6'h00;
			out_idx <= 3'h0;
			so <= 1'b0;
			so_oe_n <= 1'b1;
		end else begin
			sclk_q <= SCLK;
			cs_n_q <= CS_N;
			link_st <= next_link_st;
			command_address_bits <= next_command_address_bits;
			bit_cnt <= next_bit_cnt;
			out_idx <= next_out_idx;
			so <= next_so;
			so_oe_n <= next_so_oe_n;
		end
	end

	// erase engine and write enable latch
	always_comb begin
		next_erase_st = erase_st;
		next_erase_cnt = erase_cnt;
		next_wipe_seen = wipe_seen;
		next_busy = busy;
		next_we_latch = we_latch;
		next_start = 1'b0;
		next_area = area;
		// one-byte write-enable commands, refused while an erase runs
		if (link_st == sre_pkg::SRE_L_SHIFT && cs_rise && !busy &&
			bit_cnt == `SRE_BITS_OPCODE) begin
			if (opcode_short == `SRE_OP_WREN) begin
				next_we_latch = 1'b1;
			end else if (opcode_short == `SRE_OP_WRDI) begin
				next_we_latch = 1'b0;
			end
		end
		case (erase_st)
			sre_pkg::SRE_E_IDLE: begin
				if (erase_ok) begin
					next_erase_st = sre_pkg::SRE_E_RUN;
					next_erase_cnt = 24'h00_0000;
					next_wipe_seen = 1'b0;
					next_busy = 1'b1;
					next_start = 1'b1;
					next_area = area_of(command_address_bits);
				end
			end
			sre_pkg::SRE_E_RUN: begin
				// the timer runs the full erase time; the wipe ends well inside it
				if (link_if.erase_done) begin
					next_wipe_seen = 1'b1;
				end
				if (erase_cnt != ERASE_LAST) begin
					next_erase_cnt = erase_cnt + 24'h00_0001;
				end else if (wipe_seen || link_if.erase_done) begin
					next_erase_st = sre_pkg::SRE_E_IDLE;
					next_busy = 1'b0;
					next_we_latch = 1'b0;
				end
			end
			default: begin
				next_erase_st = sre_pkg::SRE_E_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			erase_st <= sre_pkg::SRE_E_IDLE;
			erase_cnt <= 24'h00_0000;
			wipe_seen <= 1'b0;
			busy <= 1'b0;
			we_latch <= 1'b0;
			start <= 1'b0;
			area <= 2'h1;
		end else begin
			erase_st <= next_erase_st;
			erase_cnt <= next_erase_cnt;
			wipe_seen <= next_wipe_seen;
			busy <= next_busy;
			we_latch <= next_we_latch;
			start <= next_start;
			area <= next_area;
		end
	end

	// store hookup; programming is held off while an erase runs
	assign link_if.erase_start = start;
	assign link_if.erase_area = area;
	assign link_if.rd_area = AREA_RD_SEL;
	assign link_if.rd_addr = AREA_RD_ADDR;
	assign link_if.wr_en = AREA_WR_EN & ~busy;
	assign link_if.wr_area = AREA_WR_SEL;
	assign link_if.wr_addr = AREA_WR_ADDR;
	assign link_if.wr_data = AREA_WR_DATA;

	sre_area_store u_store (
		.clk(CLK),
		.rst(SYS_RST),
		.bus(link_if.store)
	);

	// extra stage so the read data leaves from a top-level flop
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rd_data <= `SRE_ERASED_BYTE;
		end else begin
			rd_data <= link_if.rd_data;
		end
	end

	assign SO = so;
	assign SO_OE_N = so_oe_n;
	assign BUSY = busy;
	assign WRITE_ENABLE_LATCH = we_latch;
	assign AREA_RD_DATA = rd_data;

endmodule

`default_nettype wire

// ==== rtl/sre_consts.svh ====
// constants for the security area erase sequencer
// assumes inclusion by every rtl file that needs offsets, opcodes or timings
`ifndef SRE_CONSTS_SVH
`define SRE_CONSTS_SVH

// opcodes on the single-line serial link
`define SRE_OP_ERASE 8'h44
`define SRE_OP_WREN 8'h06
`define SRE_OP_WRDI 8'h04
`define SRE_OP_RDSR 8'h05

// frame lengths in link bits
`define SRE_BITS_OPCODE 6'h08
`define SRE_BITS_ERASE 6'h20

// address field layout of the erase frame
`define SRE_ADDR_HI_MSB 23
`define SRE_ADDR_HI_LSB 16
`define SRE_ADDR_SEL_MSB 15
`define SRE_ADDR_SEL_LSB 12
`define SRE_ADDR_MID_MSB 11
`define SRE_ADDR_MID_LSB 8

// status byte field positions
`define SRE_STAT_BUSY 0
`define SRE_STAT_WE_LATCH 1

// area geometry and erased value
`define SRE_AREA_BYTES 256
`define SRE_AREA_COUNT 3
`define SRE_ERASED_BYTE 8'hff

// self-timed erase duration: plain default in us, clock in MHz
`define SRE_T_SE_US 100
`define SRE_CLK_MHZ 125
`define SRE_ERASE_CYCLES (`SRE_T_SE_US * `SRE_CLK_MHZ)

`endif

// ==== rtl/sre_pkg.sv ====
// types shared by the security area erase sequencer
// assumes nothing beyond a SystemVerilog compiler
package sre_pkg;

	// link receiver states, one-hot
	typedef enum logic [2:0] {
		SRE_L_IDLE = 3'b001,
		SRE_L_SHIFT = 3'b010,
		SRE_L_STAT = 3'b100
	} sre_link_t;

	// erase engine states, one-hot
	typedef enum logic [1:0] {
		SRE_E_IDLE = 2'b01,
		SRE_E_RUN = 2'b10
	} sre_erase_t;

	// area select, 1..3 valid
	typedef logic [1:0] sre_area_t;

endpackage

// ==== rtl/sre_if.sv ====
// carrier between the sequencer and its area store
// assumes both ends run on one clock
`timescale 1ns/1ps
`default_nettype none

interface sre_if;
	logic erase_start;
	sre_pkg::sre_area_t erase_area;
	logic erase_done;
	sre_pkg::sre_area_t rd_area;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	sre_pkg::sre_area_t wr_area;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	modport seq (output erase_start, output erase_area, input erase_done,
		output rd_area, output rd_addr, input rd_data,
		output wr_en, output wr_area, output wr_addr, output wr_data);
	modport store (input erase_start, input erase_area, output erase_done,
		input rd_area, input rd_addr, output rd_data,
		input wr_en, input wr_area, input wr_addr, input wr_data);
endinterface

`default_nettype wire

// ==== rtl/sre_area_store.sv ====
// three security areas of 256 bytes with a byte-wise wipe engine
// assumes erase_start only while no wipe runs; writes are held off meanwhile
`timescale 1ns/1ps
`default_nettype none
`include "sre_consts.svh"

module sre_area_store (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sequencer side
	sre_if.store bus
);

	logic [7:0] mem [0:(`SRE_AREA_COUNT * `SRE_AREA_BYTES) - 1];
	logic wiping;
	logic [7:0] widx;
	sre_pkg::sre_area_t warea;
	logic done;
	logic [7:0] rdata;
	logic next_wiping;
	logic [7:0] next_widx;
	sre_pkg::sre_area_t next_warea;
	logic next_done;

	// flat index of a byte; areas 1..3 map onto rows 0..2
	function automatic logic [9:0] flat_idx(input sre_pkg::sre_area_t a, input logic [7:0] b);
		logic [1:0] row;
		row = a - 2'h1;
		flat_idx = {row, b};
	endfunction

	// wipe walks every byte of one area, one per clock
	always_comb begin
		next_wiping = wiping;
		next_widx = widx;
		next_warea = warea;
		next_done = 1'b0;
		if (!wiping && bus.erase_start) begin
			next_wiping = 1'b1;
			next_widx = 8'h00;
			next_warea = bus.erase_area;
		end else if (wiping) begin
			next_widx = widx + 8'h01;
			if (widx == 8'hff) begin
				next_wiping = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wiping <= 1'b0;
			widx <= 8'h00;
			warea <= 2'h1;
			done <= 1'b0;
		end else begin
			wiping <= next_wiping;
			widx <= next_widx;
			warea <= next_warea;
			done <= next_done;
		end
	end

	// array writes: wipe to the erased value, programming only clears bits
	always_ff @(posedge clk) begin
		if (wiping) begin
			mem[flat_idx(warea, widx)] <= `SRE_ERASED_BYTE;
		end else if (bus.wr_en && bus.wr_area != 2'h0) begin
			mem[flat_idx(bus.wr_area, bus.wr_addr)] <=
				mem[flat_idx(bus.wr_area, bus.wr_addr)] & bus.wr_data;
		end
	end

	// registered read; an unmapped area reads as erased
	always_ff @(posedge clk) begin
		if (bus.rd_area == 2'h0) begin
			rdata <= `SRE_ERASED_BYTE;
		end else begin
			rdata <= mem[flat_idx(bus.rd_area, bus.rd_addr)];
		end
	end

	assign bus.erase_done = done;
	assign bus.rd_data = rdata;

endmodule

`default_nettype wire

// ==== test/sre_top_asserts.sv ====
// port-level checks on the security area erase sequencer
// assumes binding into sre_top, ERASE_CYCLES handed on from the instance
`timescale 1ns/1ps
`default_nettype none

module sre_chk #(
	parameter int ERASE_CYCLES = 300
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// link and mode
	input wire logic CS_N,
	input wire logic SO_OE_N,
	input wire logic QPI_MODE,
	// status
	input wire logic BUSY,
	input wire logic WRITE_ENABLE_LATCH
);
	int busy_cnt;
	int next_busy_cnt;

	// busy length counter, so a long erase needs no long repetition
	always_comb begin
		next_busy_cnt = BUSY ? busy_cnt + 1 : 0;
	end
	always_ff @(posedge CLK) begin
		busy_cnt <= SYS_RST ? 0 : next_busy_cnt;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	// erase start and end as two-step edges
	sequence s_busy_on;
		!BUSY ##1 BUSY;
	endsequence
	sequence s_busy_end;
		BUSY ##1 !BUSY;
	endsequence

	property p_start;
		s_busy_on |-> $past(CS_N) && !$past(CS_N, 2);
	endproperty
	property p_need_wel;
		s_busy_on |-> $past(WRITE_ENABLE_LATCH);
	endproperty
	property p_no_qpi;
		s_busy_on |-> !$past(QPI_MODE);
	endproperty
	property p_hold;
		s_busy_on |=> BUSY [*8];
	endproperty
	property p_len;
		s_busy_end |-> busy_cnt == ERASE_CYCLES;
	endproperty
	property p_wel_clr;
		s_busy_end |-> !WRITE_ENABLE_LATCH;
	endproperty
	property p_wel_keep;
		BUSY && $past(BUSY) |-> $stable(WRITE_ENABLE_LATCH);
	endproperty
	property p_oe_idle;
		CS_N [*3] |-> SO_OE_N;
	endproperty

	a_start: assert property (p_start) else $error("busy rose off the frame end");
	a_need_wel: assert property (p_need_wel) else $error("erase ran without write enable");
	a_no_qpi: assert property (p_no_qpi) else $error("erase ran in four-line mode");
	a_hold: assert property (p_hold) else $error("busy dropped early");
	a_len: assert property (p_len) else $error("erase length wrong");
	a_wel_clr: assert property (p_wel_clr) else $error("write enable kept after erase");
	a_wel_keep: assert property (p_wel_keep) else $error("write enable moved while busy");
	a_oe_idle: assert property (p_oe_idle) else $error("so driven while idle");
endmodule

bind sre_top sre_chk #(.ERASE_CYCLES(ERASE_CYCLES)) chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.CS_N(CS_N), .SO_OE_N(SO_OE_N), .QPI_MODE(QPI_MODE), .BUSY(BUSY),
	.WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));

`default_nettype wire

// ==== test/sre_host_model.sv ====
// host side of the serial link: sends frames, collects read-back bits
// assumes the device samples SCLK with CLK, so phases span whole cycles
`timescale 1ns/1ps
`default_nettype none

module sre_host_model (
	// clock
	input wire logic CLK,
	// serial link
	output logic CS_N,
	output logic SCLK,
	output logic SI,
	input wire logic SO,
	input wire logic SO_OE_N
);
	logic [7:0] stat = 8'h00;
	logic oe_bad = 1'b0;

	// link idles deselected with the clock parked low
	initial begin
		CS_N = 1'b1;
		SCLK = 1'b0;
		SI = 1'b0;
	end

	// n bits of d, msb first; bits after falls 8..15 land in stat
	task automatic frame(input logic [39:0] d, input int n);
		@(posedge CLK) CS_N <= 1'b0;
		oe_bad = 1'b0;
		repeat (2) @(posedge CLK);
		for (int i = 1; i <= n; i++) begin
			SI <= d[n - i];
			@(posedge CLK) SCLK <= 1'b1;
			repeat (2) @(posedge CLK);
			SCLK <= 1'b0;
			repeat (3) @(posedge CLK);
			if (i >= 8 && i <= 15) begin
				stat = {stat[6:0], SO};
				oe_bad = oe_bad | SO_OE_N;
			end
		end
		CS_N <= 1'b1;
		SI <= ~SI; // released line must not look held
		repeat (3) @(posedge CLK);
	endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the security area erase sequencer
// assumes host model and checker compiled first; erase shortened to 300
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int ERASE_CYCLES = 300;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, sclk, si, so, so_oe_n, busy, we_latch;
	logic qpi = 1'b0;
	logic [2:0] lock = 3'h0;
	logic [1:0] rd_sel = 2'h0;
	logic [7:0] rd_addr = 8'h00;
	logic [7:0] rd_data;
	logic wr_en = 1'b0;
	logic [1:0] wr_sel = 2'h0;
	logic [7:0] wr_addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	int err_count = 0;
	int checks = 0;
	// refused erase frames: no write enable, qpi, bad high, bad mid, area 0, area 4,
	// locked, 31 bits, 33 bits, wrong opcode
	logic [39:0] tbl_d [10] = '{40'h44001000, 40'h44001000, 40'h44011000, 40'h44001100,
		40'h44000000, 40'h44004000, 40'h44001000, 40'h22000800, 40'h88002000, 40'h45001000};
	int tbl_n [10] = '{32, 32, 32, 32, 32, 32, 32, 31, 33, 32};

	always #4 clk = ~clk;

	sre_top #(.ERASE_CYCLES(ERASE_CYCLES)) uut (.CLK(clk), .SYS_RST(rst), .CS_N(cs_n),
		.SCLK(sclk), .SI(si), .SO(so), .SO_OE_N(so_oe_n), .QPI_MODE(qpi),
		.OTP_AREA_LOCK_BITS(lock), .BUSY(busy), .WRITE_ENABLE_LATCH(we_latch),
		.AREA_RD_SEL(rd_sel), .AREA_RD_ADDR(rd_addr), .AREA_RD_DATA(rd_data),
		.AREA_WR_EN(wr_en), .AREA_WR_SEL(wr_sel), .AREA_WR_ADDR(wr_addr),
		.AREA_WR_DATA(wr_data));
	sre_host_model host (.CLK(clk), .CS_N(cs_n), .SCLK(sclk), .SI(si), .SO(so),
		.SO_OE_N(so_oe_n));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// status poll, also checks the output enable during read-back
	task automatic status;
		host.frame(40'h0500, 16);
		chk({7'h0, host.oe_bad}, 8'h00);
	endtask

	// bounded poll until the device reports idle, then a check that write enable is gone
	task automatic wait_idle;
		status;
		for (int i = 0; i < 20 && host.stat[0] !== 1'b0; i++)
			status;
		chk(host.stat, 8'h00);
	endtask

	task automatic erase(input logic [3:0] a);
		host.frame({8'h44, 8'h00, a, 4'h0, 8'ha5}, 32);
	endtask

	task automatic prog(input logic [1:0] a, input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk) begin
			wr_en <= 1'b1;
			wr_sel <= a;
			wr_addr <= ad;
			wr_data <= dt;
		end
		@(posedge clk) wr_en <= 1'b0;
	endtask

	// read data settles two edges after the address
	task automatic rd(input logic [1:0] a, input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clk) begin
			rd_sel <= a;
			rd_addr <= ad;
		end
		repeat (3) @(posedge clk);
		chk(rd_data, exp);
	endtask

	// main sequence: erase each area, refusals, then lock isolation
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({busy, we_latch, so_oe_n, 5'h0}, 8'h20);
		rd(2'h0, 8'h00, 8'hff);
		for (int a = 1; a <= 3; a++) begin
			host.frame(40'h06, 8);
			status;
			chk(host.stat, 8'h02);
			erase(a[3:0]);
			chk({7'h0, busy}, 8'h01);
			status;
			chk(host.stat, 8'h03);
			wait_idle;
			rd(a[1:0], 8'h00, 8'hff);
			rd(a[1:0], 8'hff, 8'hff);
		end
		prog(2'h1, 8'h10, 8'h5a);
		prog(2'h2, 8'h10, 8'h3c);
		prog(2'h3, 8'h10, 8'h0f);
		for (int i = 0; i < 10; i++) begin
			if (i != 0)
				host.frame(40'h06, 8);
			qpi <= (i == 1);
			lock <= (i == 6) ? 3'h1 : 3'h0;
			host.frame(tbl_d[i], tbl_n[i]);
			qpi <= 1'b0;
			lock <= 3'h0;
			repeat (4) @(posedge clk);
			chk({7'h0, busy}, 8'h00);
			rd(2'h1, 8'h10, 8'h5a);
		end
		host.frame(40'h04, 8);
		status;
		chk(host.stat, 8'h00);
		// status poll in four-line mode must leave the output released
		qpi <= 1'b1;
		host.frame(40'h0500, 16);
		chk({7'h0, host.oe_bad}, 8'h01);
		qpi <= 1'b0;
		lock <= 3'h1;
		host.frame(40'h06, 8);
		erase(4'h2);
		// a second erase while busy must be refused, area 3 keeps its byte
		erase(4'h3);
		wait_idle;
		rd(2'h2, 8'h10, 8'hff);
		rd(2'h1, 8'h10, 8'h5a);
		rd(2'h3, 8'h10, 8'h0f);
		give_verdict;
	end

	// watchdog well beyond the expected run of some 6000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		$display("unexpected at %0t: watchdog", $time);
		give_verdict;
	end
endmodule

`default_nettype wire
